/* File: verilog/ftiq_regs.sv */
/*
 * frequency tracking configuration, pi gains and iq trim registers
 * behind an apb slave, plus the tracking lock mode sequencer.
 * assumes apb master on ref_clk; receive status inputs synchronous.
 */
// Notes on behaviour
// - lock mode field at bits 1:0; value 0 runs the loop freely during reception
// - lock mode 1 keeps frequency tracking switched off throughout reception
// - lock mode 2 holds the correction once preamble or sync is detected
// - lock mode 3 locks after preamble, or sync only when tolerance is zero
// - proportional gain field at bits 7:4 gives gain two to the n
// - integral gain field at bits 3:0 gives gain two to the n
// - phase trim bits 6:0 set the iq phase correction
// - amplitude trim bits 6:0 set the iq amplitude correction
`timescale 1ns/1ps
`default_nettype none

module ftiq_regs #(
    parameter int TRIM_W = ftiq_pkg::TRIM_W,
    parameter int GAIN_W = ftiq_pkg::GAIN_W
) (
    input  wire logic                            ref_clk,
    input  wire logic                            rst,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [ftiq_pkg::APB_ADDR_W-1:0] paddr,
    input  wire logic [ftiq_pkg::APB_DATA_W-1:0] pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [ftiq_pkg::APB_DATA_W-1:0] prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    input  wire logic                            rxActive,
    input  wire logic                            preambleDetected,
    input  wire logic                            syncDetected,
    input  wire logic [3:0]                      preambleTolerance,
    output logic                                 freqTrackRun,
    output logic                                 freqTrackFrozen,
    output logic                                 freqTrackPolarity,
    output logic [ftiq_pkg::SCHEME_W-1:0]        freqTrackScheme,
    output logic [ftiq_pkg::LOCK_W-1:0]          freqTrackLockMode,
    output logic [GAIN_W-1:0]                    freqTrackPropGain,
    output logic [GAIN_W-1:0]                    freqTrackIntGain,
    output logic [TRIM_W-1:0]                    iqPhaseTrim,
    output logic [TRIM_W-1:0]                    iqAmplitudeTrim
);

    // elaboration checks
    if (TRIM_W != ftiq_pkg::TRIM_W) begin : g_bad_trim
        $error("trim width must match the seven-bit trim fields");
    end
    if (GAIN_W != ftiq_pkg::GAIN_W) begin : g_bad_gain
        $error("gain width must be sixteen for four-bit exponents");
    end

    // word index compare
    function automatic logic wordHit(input logic [9:0] word, input logic [8:0] idx);
        wordHit = (word == {1'b0, idx});
    endfunction : wordHit

    logic [ftiq_pkg::REG_W-1:0]      regFile_reg [ftiq_pkg::NUM_RW_REGS];
    logic [ftiq_pkg::NUM_RW_REGS-1:0] rwHit;
    logic [9:0]                       wordAddr;
    logic                             statusHit;
    logic                             anyHit;
    logic                             setupPhase;
    logic                             accessPhase;
    logic                             writeStrobe;
    logic [ftiq_pkg::APB_DATA_W-1:0]  prdata_next;
    logic                             pslverr_next;
    logic [7:0]                       statusWord;
    logic [ftiq_pkg::LOCK_W-1:0]      lockField;
    logic                             freezeEvent;
    logic                             syncMayLock;

    ftiq_pkg::ftiq_state_t state_reg;
    ftiq_pkg::ftiq_state_t state_next;

    assign wordAddr    = paddr[11:2];
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;

    // address decode of the writable registers
    for (genvar r = 0; r < ftiq_pkg::NUM_RW_REGS; r++) begin : g_hit
        assign rwHit[r] = wordHit(wordAddr, ftiq_pkg::REG_IDX[r]);
    end

    assign statusHit = wordHit(wordAddr, ftiq_pkg::IDX_STATUS);
    assign anyHit    = (|rwHit) || statusHit;

    // zero wait state slave
    assign pready = accessPhase;

    // writes land only in the access phase, low byte lane carries the data
    assign writeStrobe = accessPhase && pwrite && pstrb[0];

    // register storage; reserved bits masked to zero
    for (genvar r = 0; r < ftiq_pkg::NUM_RW_REGS; r++) begin : g_reg
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                regFile_reg[r] <= ftiq_pkg::REG_RST[r];
            end else if (writeStrobe && rwHit[r]) begin
                regFile_reg[r] <= pwdata[7:0] & ftiq_pkg::REG_MASK[r];
            end
        end
    end

    // status readback of the tracking sequencer
    always_comb begin
        statusWord = 8'h00;
        statusWord[ftiq_pkg::STAT_STATE_LSB +: 2] = state_reg;
        statusWord[ftiq_pkg::STAT_RUN_BIT]        = freqTrackRun;
        statusWord[ftiq_pkg::STAT_FROZEN_BIT]     = freqTrackFrozen;
        statusWord[ftiq_pkg::STAT_RX_BIT]         = rxActive;
    end

    // read data and error, prepared in the setup phase
    always_comb begin
        prdata_next  = '0;
        pslverr_next = 1'b0;
        if (!anyHit) begin
            pslverr_next = 1'b1;
        end else if (statusHit) begin
            if (pwrite) begin
                pslverr_next = 1'b1;
            end else begin
                prdata_next[7:0] = statusWord;
            end
        end else if (!pwrite) begin
            for (int r = 0; r < ftiq_pkg::NUM_RW_REGS; r++) begin
                if (rwHit[r]) begin
                    prdata_next[7:0] = regFile_reg[r];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata  <= prdata_next;
            pslverr <= pslverr_next;
        end else if (!psel) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

    // configuration fields
    assign lockField = regFile_reg[ftiq_pkg::SLOT_CONFIG][ftiq_pkg::LOCK_LSB +: 2];

    assign freqTrackLockMode = lockField;
    assign freqTrackPolarity = regFile_reg[ftiq_pkg::SLOT_CONFIG][ftiq_pkg::POLARITY_BIT];
    assign freqTrackScheme   = regFile_reg[ftiq_pkg::SLOT_CONFIG][ftiq_pkg::SCHEME_LSB +: 2];

    // trims straight from their registers
    assign iqPhaseTrim     = regFile_reg[ftiq_pkg::SLOT_PHASE][ftiq_pkg::TRIM_LSB +: 7];
    assign iqAmplitudeTrim = regFile_reg[ftiq_pkg::SLOT_AMPLITUDE][ftiq_pkg::TRIM_LSB +: 7];

    // pi gains, exponent to power of two
    ftiq_pow2_decode #(
        .CODE_W (ftiq_pkg::GAIN_CODE_W),
        .GAIN_W (GAIN_W)
    ) u_prop_gain (
        .ref_clk (ref_clk),
        .rst     (rst),
        .code    (regFile_reg[ftiq_pkg::SLOT_GAINS][ftiq_pkg::PROP_GAIN_LSB +: 4]),
        .gain    (freqTrackPropGain)
    );

    ftiq_pow2_decode #(
        .CODE_W (ftiq_pkg::GAIN_CODE_W),
        .GAIN_W (GAIN_W)
    ) u_int_gain (
        .ref_clk (ref_clk),
        .rst     (rst),
        .code    (regFile_reg[ftiq_pkg::SLOT_GAINS][ftiq_pkg::INT_GAIN_LSB +: 4]),
        .gain    (freqTrackIntGain)
    );

    // sync only counts in lock mode when no preamble errors are tolerated
    assign syncMayLock = (preambleTolerance == ftiq_pkg::TOL_EXACT);

    // event that freezes the correction for the current mode
    always_comb begin
        case (lockField)
            ftiq_pkg::LOCK_HOLD: begin
                freezeEvent = preambleDetected || syncDetected;
            end
            ftiq_pkg::LOCK_LOCK: begin
                freezeEvent = preambleDetected || (syncDetected && syncMayLock);
            end
            default: begin
                freezeEvent = 1'b0;
            end
        endcase
    end

    // tracking sequencer
    always_comb begin
        state_next = state_reg;
        if (!rxActive) begin
            state_next = ftiq_pkg::ST_IDLE;
        end else if (lockField == ftiq_pkg::LOCK_OFF) begin
            state_next = ftiq_pkg::ST_OFF;
        end else begin
            case (state_reg)
                ftiq_pkg::ST_IDLE: begin
                    state_next = freezeEvent ? ftiq_pkg::ST_FROZEN : ftiq_pkg::ST_TRACK;
                end
                ftiq_pkg::ST_TRACK: begin
                    if (freezeEvent) begin
                        state_next = ftiq_pkg::ST_FROZEN;
                    end
                end
                ftiq_pkg::ST_FROZEN: begin
                    if (lockField == ftiq_pkg::LOCK_FREE) begin
                        state_next = ftiq_pkg::ST_TRACK;
                    end
                end
                ftiq_pkg::ST_OFF: begin
                    state_next = freezeEvent ? ftiq_pkg::ST_FROZEN : ftiq_pkg::ST_TRACK;
                end
                default: begin
                    state_next = ftiq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= ftiq_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // loop control outputs follow the sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            freqTrackRun    <= 1'b0;
            freqTrackFrozen <= 1'b0;
        end else begin
            freqTrackRun    <= (state_next == ftiq_pkg::ST_TRACK);
            freqTrackFrozen <= (state_next == ftiq_pkg::ST_FROZEN);
        end
    end

endmodule : ftiq_regs

`default_nettype wire

/* File: inc/ftiq_pkg.sv */
/*
 * constants and types for the frequency tracking and iq trim register bank.
 * assumes a 32-bit apb master; registers sit at word index * 4.
 */
`default_nettype none

package ftiq_pkg;

    localparam int          APB_ADDR_W    = 12;
    localparam int          APB_DATA_W    = 32;
    localparam int          REG_W         = 8;
    localparam int          NUM_RW_REGS   = 4;

    // register word indices; byte address is index * 4
    localparam logic [8:0]  IDX_CONFIG    = 9'h0116;
    localparam logic [8:0]  IDX_GAINS     = 9'h0117;
    localparam logic [8:0]  IDX_PHASE     = 9'h0118;
    localparam logic [8:0]  IDX_AMPLITUDE = 9'h0119;
    localparam logic [8:0]  IDX_STATUS    = 9'h011F;

    // slots of the writable registers in the register array
    localparam int          SLOT_CONFIG    = 0;
    localparam int          SLOT_GAINS     = 1;
    localparam int          SLOT_PHASE     = 2;
    localparam int          SLOT_AMPLITUDE = 3;

    localparam logic [8:0]  REG_IDX  [NUM_RW_REGS] = '{IDX_CONFIG, IDX_GAINS,
                                                      IDX_PHASE, IDX_AMPLITUDE};

    // implemented bits; reserved bits store nothing and read zero
    localparam logic [7:0]  REG_MASK [NUM_RW_REGS] = '{8'h1F, 8'hFF, 8'h7F, 8'h7F};

    // values after reset
    localparam logic [7:0]  REG_RST  [NUM_RW_REGS] = '{8'h08, 8'h37, 8'h00, 8'h00};

    // config fields
    localparam int          LOCK_LSB      = 0;
    localparam int          LOCK_W        = 2;
    localparam int          SCHEME_LSB    = 2;
    localparam int          SCHEME_W      = 2;
    localparam int          POLARITY_BIT  = 4;

    // gains fields
    localparam int          INT_GAIN_LSB  = 0;
    localparam int          PROP_GAIN_LSB = 4;
    localparam int          GAIN_CODE_W   = 4;
    localparam int          GAIN_W        = 16;

    // trim fields
    localparam int          TRIM_LSB      = 0;
    localparam int          TRIM_W        = 7;

    // status fields
    localparam int          STAT_STATE_LSB  = 0;
    localparam int          STAT_RUN_BIT    = 2;
    localparam int          STAT_FROZEN_BIT = 3;
    localparam int          STAT_RX_BIT     = 4;

    // preamble tolerance value that permits locking on sync
    localparam logic [3:0]  TOL_EXACT     = 4'h0;

    typedef enum logic [1:0] {
        LOCK_FREE = 2'b00,
        LOCK_OFF  = 2'b01,
        LOCK_HOLD = 2'b10,
        LOCK_LOCK = 2'b11
    } ftiq_lock_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_TRACK  = 2'b01,
        ST_FROZEN = 2'b10,
        ST_OFF    = 2'b11
    } ftiq_state_t;

endpackage : ftiq_pkg

`default_nettype wire

/* File: verilog/ftiq_pow2_decode.sv */
/*
 * registered decode of a gain exponent into a one-hot power of two.
 * assumes code comes from a register in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module ftiq_pow2_decode #(
    parameter int CODE_W = ftiq_pkg::GAIN_CODE_W,
    parameter int GAIN_W = ftiq_pkg::GAIN_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [CODE_W-1:0] code,
    output logic      [GAIN_W-1:0] gain
);

    // elaboration check
    if (GAIN_W != (1 << CODE_W)) begin : g_bad_width
        $error("gain width must be two to the power of code width");
    end

    // gain = 2**code, one bit per code value
    for (genvar i = 0; i < GAIN_W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                gain[i] <= 1'b0;
            end else begin
                gain[i] <= (code == CODE_W'(i));
            end
        end
    end

endmodule : ftiq_pow2_decode

`default_nettype wire

/* File: verif/ftiq_regs_checker.sv */
/* assertions on the ports of ftiq_regs.
   bound from the bench top; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module ftiq_regs_checker #(
    parameter int TRIM_W = 7,
    parameter int GAIN_W = 16
) (
    input wire logic              ref_clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              rxActive,
    input wire logic              preambleDetected,
    input wire logic              syncDetected,
    input wire logic [3:0]        preambleTolerance,
    input wire logic              freqTrackRun,
    input wire logic              freqTrackFrozen,
    input wire logic [1:0]        freqTrackLockMode,
    input wire logic [GAIN_W-1:0] freqTrackPropGain,
    input wire logic [TRIM_W-1:0] iqPhaseTrim
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence apb_acc;
        psel && penable;
    endsequence
    sequence reg_wr(idx);
        apb_acc ##0 (pwrite && pstrb[0] && paddr[11:2] == idx);
    endsequence
    pready_comb_a: assert property (pready == (psel && penable))
        else $error("pready not equal to access phase");
    gain_decode_a: assert property (reg_wr(ftiq_pkg::IDX_GAINS) |-> ##2
        freqTrackPropGain == (GAIN_W'(1) << $past(pwdata[7:4], 2)))
        else $error("proportional gain not two to the code");
    trim_write_a: assert property (reg_wr(ftiq_pkg::IDX_PHASE) |=>
        iqPhaseTrim == $past(pwdata[6:0])) else $error("phase trim not written");
    trim_read_a: assert property (apb_acc ##0 (!pwrite && paddr[11:2] == ftiq_pkg::IDX_PHASE)
        |-> prdata == 32'(iqPhaseTrim)) else $error("phase trim read wrong");
    unmapped_err_a: assert property (apb_acc ##0 (paddr[11:2] < ftiq_pkg::IDX_CONFIG)
        |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
    free_run_a: assert property (rxActive && freqTrackLockMode == 2'h0 |=>
        freqTrackRun && !freqTrackFrozen) else $error("free mode not running");
    track_off_a: assert property (freqTrackLockMode == 2'h1 |=>
        !freqTrackRun && !freqTrackFrozen) else $error("disabled mode active");
    hold_freeze_a: assert property (rxActive && freqTrackLockMode == 2'h2 &&
        (preambleDetected || syncDetected) |=> freqTrackFrozen && !freqTrackRun)
        else $error("hold mode did not freeze");
    lock_pre_a: assert property (rxActive && freqTrackLockMode == 2'h3 &&
        preambleDetected |=> freqTrackFrozen) else $error("lock mode did not lock");
    sync_gate_a: assert property (rxActive && freqTrackLockMode == 2'h3 &&
        !freqTrackFrozen && !preambleDetected && preambleTolerance != 4'h0 |=>
        !freqTrackFrozen) else $error("locked on sync with tolerance set");
endmodule : ftiq_regs_checker
`default_nettype wire

/* File: verif/ftiq_regs_tb_top.sv */
/* self-checking bench for ftiq_regs: apb master, register rows, sequencer.
   assumes ftiq_pkg and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module ftiq_regs_tb_top;
    typedef struct packed {logic [8:0] idx; logic [7:0] wr; logic [7:0] exp;} ftiq_row_t;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0]  pstrb = 4'hF, tol = 4'h0;
    logic        pready, pslverr, er, run, frz, pol;
    logic        rxActive = 1'b0, preambleDetected = 1'b0, syncDetected = 1'b0;
    logic [1:0]  scheme, lockMode;
    logic [15:0] propGain, intGain;
    logic [6:0]  phaseTrim, ampTrim;
    int          miscompares = 0, checked = 0;
    ftiq_row_t   rows [5] = '{'{ftiq_pkg::IDX_CONFIG, 8'hFF, 8'h1F},
        '{ftiq_pkg::IDX_GAINS, 8'h5A, 8'h5A}, '{ftiq_pkg::IDX_PHASE, 8'hFF, 8'h7F},
        '{ftiq_pkg::IDX_AMPLITUDE, 8'h81, 8'h01}, '{ftiq_pkg::IDX_CONFIG, 8'hE9, 8'h09}};

    ftiq_regs ftiq_regs_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxActive(rxActive),
        .preambleDetected(preambleDetected), .syncDetected(syncDetected),
        .preambleTolerance(tol), .freqTrackRun(run), .freqTrackFrozen(frz),
        .freqTrackPolarity(pol), .freqTrackScheme(scheme), .freqTrackLockMode(lockMode),
        .freqTrackPropGain(propGain), .freqTrackIntGain(intGain),
        .iqPhaseTrim(phaseTrim), .iqAmplitudeTrim(ampTrim));

    initial forever #5 ref_clk = ~ref_clk;

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [8:0] idx, input logic [7:0] wd,
                       input logic [3:0] st);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        pstrb <= st;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic seq(input logic [1:0] m, input logic [3:0] t, input logic p,
                       input logic s, input logic f);
        apb(1'b1, ftiq_pkg::IDX_CONFIG, {4'h0, 2'h2, m}, 4'hF); // polarity 0, scheme 2
        tol <= t;
        rxActive <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({lockMode, run}, {m, m != 2'h1}); // runs unless disabled
        preambleDetected <= p;
        syncDetected <= s;
        @(posedge ref_clk);
        preambleDetected <= 1'b0;
        syncDetected <= 1'b0;
        @(posedge ref_clk);
        chk({run, frz}, {m != 2'h1 && !f, f}); // freeze result
        apb(1'b0, ftiq_pkg::IDX_STATUS, 8'h00, 4'hF);
        chk(rd, {27'h0, 1'b1, f, m != 2'h1 && !f, f ? 2'h2 : (m == 2'h1 ? 2'h3 : 2'h1)});
        rxActive <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({run, frz}, 2'b00); // idle outside reception
    endtask : seq

    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({propGain, intGain}, 32'h0008_0080); // reset gains
        chk({pol, scheme, lockMode}, 5'h08); // reset config
        apb(1'b0, ftiq_pkg::IDX_GAINS, 8'h00, 4'hF);
        chk(rd, 32'h0000_0037); // reset gains word
        $display("test reset done");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].idx, rows[i].wr, 4'hF);
            apb(1'b0, rows[i].idx, 8'h00, 4'hF);
            chk({er, rd[30:0]}, {1'b0, 23'h0, rows[i].exp}); // masks
        end
        chk({phaseTrim, ampTrim}, 14'h3F81); // trim outputs
        chk({propGain, intGain}, 32'h0020_0400); // gain outputs
        chk({pol, scheme, lockMode}, 5'h09); // config outputs
        $display("test register rows done");
        for (int k = 0; k < 16; k++) begin
            apb(1'b1, ftiq_pkg::IDX_GAINS, {k[3:0], 4'hF - k[3:0]}, 4'hF);
            repeat (2) @(posedge ref_clk);
            chk({propGain, intGain}, {16'h1 << k, 16'h1 << (15 - k)}); // codes
        end
        $display("test gain codes done");
        apb(1'b1, ftiq_pkg::IDX_PHASE, 8'h55, 4'hE);
        apb(1'b0, ftiq_pkg::IDX_PHASE, 8'h00, 4'hF);
        chk(rd, 32'h0000_007F); // masked strobe leaves trim
        apb(1'b0, 9'h100, 8'h00, 4'hF);
        chk({er, rd[30:0]}, 32'h8000_0000); // unmapped refused
        apb(1'b1, ftiq_pkg::IDX_STATUS, 8'hFF, 4'hF);
        chk(er, 1'b1); // status is read only
        $display("test refusals done");
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk({phaseTrim, ampTrim, pol, scheme, lockMode}, 19'h0_0008); // mid-run reset
        chk({propGain, intGain}, 32'h0008_0080); // mid-run reset gains
        apb(1'b1, ftiq_pkg::IDX_GAINS, 8'h37, 4'hF);
        repeat (2) @(posedge ref_clk);
        chk({propGain, intGain}, 32'h0008_0080); // recommended gains
        $display("test mid-run reset done");
        for (int m = 0; m < 4; m++) begin
            seq(m[1:0], 4'h0, 1'b1, 1'b0, m >= 2); // every mode
        end
        seq(2'h3, 4'h1, 1'b0, 1'b1, 1'b0); // sync ignored with tolerance
        seq(2'h3, 4'h0, 1'b0, 1'b1, 1'b1); // sync locks when exact
        seq(2'h2, 4'h1, 1'b0, 1'b1, 1'b1); // hold takes sync
        $display("test sequencer done");
        end_of_test;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_of_test;
    end
endmodule : ftiq_regs_tb_top

bind ftiq_regs ftiq_regs_checker #(.TRIM_W(TRIM_W), .GAIN_W(GAIN_W)) ftiq_regs_checker_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxActive(rxActive), .preambleDetected(preambleDetected),
    .syncDetected(syncDetected), .preambleTolerance(preambleTolerance),
    .freqTrackRun(freqTrackRun), .freqTrackFrozen(freqTrackFrozen),
    .freqTrackLockMode(freqTrackLockMode), .freqTrackPropGain(freqTrackPropGain),
    .iqPhaseTrim(iqPhaseTrim));
`default_nettype wire
